// ---- verilog/quadrature_wheel_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Phase A and phase B each come from one of eight pins chosen by its own 3-bit selector.
// - The live edge counter is never visible on the bus.
// - In common mode without the shuttle bit the counter steps by one only once both phases have reached matching levels.
// - In double accuracy mode the counter steps by one on every edge of either phase, except when both phases change in the same cycle.
// - The snapshot register changes only when a load command copies the live counter into it or a read clears it.
// - The load bit clears itself once the copy is done so software can poll it.
// - The snapshot register holds the edge count and is cleared when software reads it.
// - Writing one to the reset bit resets the decoder and zeroes the live counter.
// - Both phases are debounced with a 3-bit window setting n so short disturbances count nothing.
// - Levels shorter than three times 2^(n+1) slow clock periods are ignored as jitter.
// - Inputs are sampled on a clock of 2^n slow clock periods.
// - The decoder runs on a 32 kHz time base so that it keeps counting in suspend.
// - The shuttle bit makes the decoder accept two phases with non-overlapping pulses.
module quadrature_wheel_decoder
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic [1:0] hresp,
  input wire logic [wheel_decoder_pkg::PIN_COUNT-1:0] wheel_pin_in
);
  import wheel_decoder_pkg::*;

  // Bus and register state
  bus_state_t state_reg;
  bus_state_t state_next;
  logic [7:0] dp_index_reg;
  logic [7:0] dp_index_next;
  logic dp_hit_reg;
  logic dp_hit_next;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  logic [7:0] snapshot_reg;
  logic [7:0] snapshot_next;
  logic [7:0] config_reg;
  logic [7:0] config_next;
  logic [7:0] pin_a_reg;
  logic [7:0] pin_a_next;
  logic [7:0] pin_b_reg;
  logic [7:0] pin_b_next;
  logic [7:0] reset_ctrl_reg;
  logic [7:0] reset_ctrl_next;
  logic [7:0] mode_reg;
  logic [7:0] mode_next;
  logic [7:0] load_reg;
  logic [7:0] load_next;

  // Decoder state
  logic [SLOW_DIV_W-1:0] div_reg;
  logic [SLOW_DIV_W-1:0] div_next;
  logic [PRESC_W-1:0] presc_reg;
  logic [PRESC_W-1:0] presc_next;
  logic [1:0] prev_reg;
  logic [1:0] prev_next;
  logic [7:0] live_reg;
  logic [7:0] live_next;

  logic slow_tick;
  logic [FILTER_W-1:0] filter_n;
  logic polarity;
  logic shuttle;
  logic double_mode;
  logic decoder_clear;
  logic [1:0] edge_seen;
  logic step_up;
  logic step_down;

  wheel_filter_if fif();

  phase_filter u_filter (
    .hclk(hclk),
    .hresetn(hresetn),
    .fif(fif)
  );

  function automatic logic [7:0] read_reg(input logic [7:0] idx, input logic hit);
    logic [7:0] val;
    val = 8'h00;
    if (hit)
    begin
      case (idx)
        EDGE_COUNT_SNAPSHOT_IDX: val = snapshot_reg;
        FILTER_POLARITY_CONFIG_IDX: val = config_reg;
        PHASE_A_PIN_SELECT_IDX: val = pin_a_reg;
        PHASE_B_PIN_SELECT_IDX: val = pin_b_reg;
        DECODER_RESET_CTRL_IDX: val = reset_ctrl_reg;
        COUNT_MODE_SELECT_IDX: val = mode_reg;
        SNAPSHOT_LOAD_CTRL_IDX: val = load_reg;
        default: val = 8'h00;
      endcase
    end
    return val;
  endfunction

  function automatic logic select_pin(input logic [7:0] sel, input logic [PIN_COUNT-1:0] pins);
    return pins[sel[PIN_SELECT_LSB +: PIN_SELECT_W]];
  endfunction

  function automatic logic [PRESC_W-1:0] sync_last(input logic [FILTER_W-1:0] n);
    logic [7:0] span;
    span = 8'h01 << n;
    return PRESC_W'(span - 8'h01);
  endfunction

  assign filter_n = config_reg[FILTER_LSB +: FILTER_W];
  assign polarity = config_reg[POLARITY_BIT];
  assign shuttle = config_reg[SHUTTLE_BIT];
  assign double_mode = mode_reg[CTRL_BIT];
  assign decoder_clear = reset_ctrl_reg[CTRL_BIT];

  assign hrdata = hrdata_reg;
  assign hreadyout = (state_reg != BUS_READ_WAIT);
  assign hresp = HRESP_OKAY;

  // Register bus
  always_comb
  begin
    state_next = state_reg;
    dp_index_next = dp_index_reg;
    dp_hit_next = dp_hit_reg;
    hrdata_next = hrdata_reg;
    snapshot_next = snapshot_reg;
    config_next = config_reg;
    pin_a_next = pin_a_reg;
    pin_b_next = pin_b_reg;
    reset_ctrl_next = reset_ctrl_reg;
    mode_next = mode_reg;
    load_next = load_reg;

    // Reset command acts for one cycle only
    reset_ctrl_next[CTRL_BIT] = 1'b0;

    unique case (state_reg)
      BUS_IDLE, BUS_READ_DONE:
      begin
        state_next = BUS_IDLE;
      end
      BUS_WRITE:
      begin
        state_next = BUS_IDLE;
        if (dp_hit_reg)
        begin
          case (dp_index_reg)
            FILTER_POLARITY_CONFIG_IDX: config_next = hwdata[7:0] & CONFIG_MASK;
            PHASE_A_PIN_SELECT_IDX: pin_a_next = hwdata[7:0] & PIN_SELECT_MASK;
            PHASE_B_PIN_SELECT_IDX: pin_b_next = hwdata[7:0] & PIN_SELECT_MASK;
            DECODER_RESET_CTRL_IDX: reset_ctrl_next = hwdata[7:0] & SINGLE_BIT_MASK;
            COUNT_MODE_SELECT_IDX: mode_next = hwdata[7:0] & SINGLE_BIT_MASK;
            SNAPSHOT_LOAD_CTRL_IDX: load_next = hwdata[7:0] & SINGLE_BIT_MASK;
            default: state_next = BUS_IDLE;
          endcase
        end
      end
      BUS_READ_WAIT:
      begin
        // The wait cycle lets a write just before land first
        state_next = BUS_READ_DONE;
        hrdata_next = {24'h00_0000, read_reg(dp_index_reg, dp_hit_reg)};
        if (dp_hit_reg && dp_index_reg == EDGE_COUNT_SNAPSHOT_IDX)
        begin
          snapshot_next = EDGE_COUNT_SNAPSHOT_RST;
        end
      end
    endcase

    if (load_reg[CTRL_BIT])
    begin
      snapshot_next = live_reg;
      load_next[CTRL_BIT] = 1'b0;
    end

    if (hsel && htrans[HTRANS_ACTIVE_BIT] && hready)
    begin
      state_next = hwrite ? BUS_WRITE : BUS_READ_WAIT;
      dp_index_next = haddr[9:2];
      dp_hit_next = (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'h0);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= BUS_IDLE;
      dp_index_reg <= 8'h00;
      dp_hit_reg <= 1'b0;
      hrdata_reg <= 32'h0000_0000;
      snapshot_reg <= EDGE_COUNT_SNAPSHOT_RST;
      config_reg <= FILTER_POLARITY_CONFIG_RST;
      pin_a_reg <= PHASE_A_PIN_SELECT_RST;
      pin_b_reg <= PHASE_B_PIN_SELECT_RST;
      reset_ctrl_reg <= DECODER_RESET_CTRL_RST;
      mode_reg <= COUNT_MODE_SELECT_RST;
      load_reg <= SNAPSHOT_LOAD_CTRL_RST;
    end
    else
    begin
      state_reg <= state_next;
      dp_index_reg <= dp_index_next;
      dp_hit_reg <= dp_hit_next;
      hrdata_reg <= hrdata_next;
      snapshot_reg <= snapshot_next;
      config_reg <= config_next;
      pin_a_reg <= pin_a_next;
      pin_b_reg <= pin_b_next;
      reset_ctrl_reg <= reset_ctrl_next;
      mode_reg <= mode_next;
      load_reg <= load_next;
    end
  end

  assign slow_tick = (div_reg == SLOW_DIV_LAST);
  // Sync strobe every 2^n ticks
  // A count left over from a wider window fires on the next slow tick instead of wrapping
  assign fif.sample_stb = slow_tick && (presc_reg >= sync_last(filter_n));
  assign fif.clear = decoder_clear;
  assign fif.raw = {select_pin(pin_b_reg, wheel_pin_in), select_pin(pin_a_reg, wheel_pin_in)} ^ {2{polarity}};
  assign edge_seen = fif.clean ^ prev_reg;

  // Edge decoding and live counter
  always_comb
  begin
    div_next = slow_tick ? '0 : div_reg + 11'h001;
    presc_next = presc_reg;
    if (fif.sample_stb)
    begin
      presc_next = '0;
    end
    else if (slow_tick)
    begin
      presc_next = presc_reg + 7'h01;
    end
    prev_next = fif.clean;
    step_up = 1'b0;
    step_down = 1'b0;

    if (shuttle)
    begin
      // Separate pulses, A up and B down
      step_up = double_mode ? edge_seen[0] : (edge_seen[0] & fif.clean[0]);
      step_down = double_mode ? edge_seen[1] : (edge_seen[1] & fif.clean[1]);
    end
    else if (edge_seen[0] ^ edge_seen[1])
    begin
      // Common mode waits for matching levels
      if (double_mode || (fif.clean[0] == fif.clean[1]))
      begin
        if (edge_seen[0])
        begin
          step_up = (fif.clean[0] != fif.clean[1]);
        end
        else
        begin
          step_up = (fif.clean[1] == fif.clean[0]);
        end
        step_down = !step_up;
      end
    end

    // Live counter has no bus path
    live_next = live_reg;
    if (step_up && !step_down)
    begin
      live_next = live_reg + 8'h01;
    end
    else if (step_down && !step_up)
    begin
      live_next = live_reg - 8'h01;
    end

    if (decoder_clear)
    begin
      live_next = LIVE_COUNT_RST;
      prev_next = 2'h0;
      presc_next = '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_reg <= '0;
      presc_reg <= '0;
      prev_reg <= 2'h0;
      live_reg <= LIVE_COUNT_RST;
    end
    else
    begin
      div_reg <= div_next;
      presc_reg <= presc_next;
      prev_reg <= prev_next;
      live_reg <= live_next;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/wheel_decoder_pkg.sv ----
`default_nettype none
package wheel_decoder_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [7:0] EDGE_COUNT_SNAPSHOT_IDX = 8'hd0;
  localparam logic [7:0] FILTER_POLARITY_CONFIG_IDX = 8'hd1;
  localparam logic [7:0] PHASE_A_PIN_SELECT_IDX = 8'hd2;
  localparam logic [7:0] PHASE_B_PIN_SELECT_IDX = 8'hd3;
  localparam logic [7:0] DECODER_RESET_CTRL_IDX = 8'hd6;
  localparam logic [7:0] COUNT_MODE_SELECT_IDX = 8'hd7;
  localparam logic [7:0] SNAPSHOT_LOAD_CTRL_IDX = 8'hd8;

  // Reset values
  localparam logic [7:0] EDGE_COUNT_SNAPSHOT_RST = 8'h00;
  localparam logic [7:0] FILTER_POLARITY_CONFIG_RST = 8'h00;
  localparam logic [7:0] PHASE_A_PIN_SELECT_RST = 8'h00;
  localparam logic [7:0] PHASE_B_PIN_SELECT_RST = 8'h01;
  localparam logic [7:0] DECODER_RESET_CTRL_RST = 8'h00;
  localparam logic [7:0] COUNT_MODE_SELECT_RST = 8'h00;
  localparam logic [7:0] SNAPSHOT_LOAD_CTRL_RST = 8'h00;
  localparam logic [7:0] LIVE_COUNT_RST = 8'h00;

  // Implemented bits of each register; the rest read as zero
  localparam logic [7:0] CONFIG_MASK = 8'h37;
  localparam logic [7:0] PIN_SELECT_MASK = 8'h07;
  localparam logic [7:0] SINGLE_BIT_MASK = 8'h01;

  // Field positions
  localparam int FILTER_LSB = 0;
  localparam int FILTER_W = 3;
  localparam int POLARITY_BIT = 4;
  localparam int SHUTTLE_BIT = 5;
  localparam int PIN_SELECT_LSB = 0;
  localparam int PIN_SELECT_W = 3;
  localparam int CTRL_BIT = 0;

  // Timing
  localparam int HCLK_PERIOD_NS = 25;
  localparam int SLOW_CLOCK_PERIOD_NS = 31250;
  localparam int SLOW_DIV_CYCLES = SLOW_CLOCK_PERIOD_NS / HCLK_PERIOD_NS;
  localparam int SLOW_DIV_W = 11;
  localparam logic [SLOW_DIV_W-1:0] SLOW_DIV_LAST = SLOW_DIV_W'(SLOW_DIV_CYCLES - 1);
  localparam int PRESC_W = 7;
  // Jitter threshold 3 * 2^(n+1) slow periods, seen through samples every 2^n periods
  localparam int FILTER_CNT_W = 3;
  localparam logic [FILTER_CNT_W-1:0] FILTER_SAMPLES = 3'h6;

  localparam int PHASES = 2;
  localparam int PIN_COUNT = 8;

  // AHB-Lite
  localparam logic [1:0] HRESP_OKAY = 2'h0;
  localparam int HTRANS_ACTIVE_BIT = 1;

  typedef enum logic [3:0] {
    BUS_IDLE = 4'b0001,
    BUS_WRITE = 4'b0010,
    BUS_READ_WAIT = 4'b0100,
    BUS_READ_DONE = 4'b1000
  } bus_state_t;
endpackage
`default_nettype wire

// ---- verilog/wheel_filter_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface wheel_filter_if;
  logic sample_stb;
  logic clear;
  logic [1:0] raw;
  logic [1:0] clean;
  modport core (output sample_stb, output clear, output raw, input clean);
  modport filter (input sample_stb, input clear, input raw, output clean);
endinterface
`default_nettype wire

// ---- verilog/phase_filter.sv ----
`timescale 1ns/1ps
`default_nettype none
module phase_filter
(
  input wire logic hclk,
  input wire logic hresetn,
  wheel_filter_if.filter fif
);
  import wheel_decoder_pkg::*;

  logic [PHASES-1:0] sample_reg;
  logic [PHASES-1:0] sample_next;
  logic [PHASES-1:0] clean_reg;
  logic [PHASES-1:0] clean_next;
  logic [PHASES-1:0][FILTER_CNT_W-1:0] cnt_reg;
  logic [PHASES-1:0][FILTER_CNT_W-1:0] cnt_next;

  assign fif.clean = clean_reg;

  genvar g;
  generate
    for (g = 0; g < PHASES; g++)
    begin : g_phase
      always_comb
      begin
        sample_next[g] = sample_reg[g];
        clean_next[g] = clean_reg[g];
        cnt_next[g] = cnt_reg[g];
        if (fif.clear)
        begin
          sample_next[g] = 1'b0;
          clean_next[g] = 1'b0;
          cnt_next[g] = '0;
        end
        else if (fif.sample_stb)
        begin
          sample_next[g] = fif.raw[g];
          if (sample_reg[g] != clean_reg[g])
          begin
            if (cnt_reg[g] == FILTER_SAMPLES - 3'h1)
            begin
              clean_next[g] = sample_reg[g];
              cnt_next[g] = '0;
            end
            else
            begin
              cnt_next[g] = cnt_reg[g] + 3'h1;
            end
          end
          else
          begin
            cnt_next[g] = '0;
          end
        end
      end

      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          sample_reg[g] <= 1'b0;
          clean_reg[g] <= 1'b0;
          cnt_reg[g] <= '0;
        end
        else
        begin
          sample_reg[g] <= sample_next[g];
          clean_reg[g] <= clean_next[g];
          cnt_reg[g] <= cnt_next[g];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ---- tb/wheel_encoder_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module wheel_encoder_model #(
  parameter int PIN_A = 3,
  parameter int PIN_B = 5
) (
  input wire logic hclk,
  output logic [7:0] wheel_pin_in
);
  logic phase_a = 1'b0;
  logic phase_b = 1'b0;
  // Unselected pins toggle every cycle, so a wrong selector loses the real edges
  logic [7:0] idle_pattern = 8'h00;
  always @(posedge hclk)
  begin
    idle_pattern <= ~idle_pattern;
  end
  always_comb
  begin
    wheel_pin_in = idle_pattern;
    wheel_pin_in[PIN_A] = phase_a;
    wheel_pin_in[PIN_B] = phase_b;
  end
  task automatic move(input logic a, input logic b, input int hold);
    @(posedge hclk);
    phase_a <= a;
    phase_b <= b;
    repeat (hold) @(posedge hclk);
  endtask
endmodule
`default_nettype wire

// ---- tb/quadrature_wheel_decoder_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module quadrature_wheel_decoder_props
  import wheel_decoder_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic [1:0] hresp,
  input wire logic [7:0] wheel_pin_in
);
  logic rd_phase;
  logic rd_mapped;
  logic [7:0] rd_idx;
  logic wr_phase;
  logic [7:0] wr_idx;
  logic [2:0] wr_age;
  logic snap_empty;
  wire logic take = hsel && htrans[HTRANS_ACTIVE_BIT] && hready;
  wire logic rd_done = rd_phase && hreadyout;
  wire logic rd_known = rd_mapped && (rd_idx inside {8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd6, 8'hd7, 8'hd8});
  wire logic rd_stall = rd_phase && !hreadyout;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Tracks bus phases; a load write marks the snapshot as possibly non-zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_phase <= 1'b0;
      rd_mapped <= 1'b0;
      rd_idx <= 8'h00;
      wr_phase <= 1'b0;
      wr_idx <= 8'h00;
      wr_age <= 3'h7;
      snap_empty <= 1'b1;
    end
    else
    begin
      if (take && !hwrite)
      begin
        rd_phase <= 1'b1;
        rd_idx <= haddr[9:2];
        rd_mapped <= (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
      end
      else if (rd_done)
        rd_phase <= 1'b0;
      wr_phase <= take && hwrite;
      if (take && hwrite)
        wr_idx <= haddr[9:2];
      wr_age <= wr_phase ? 3'h0 : ((wr_age == 3'h7) ? wr_age : wr_age + 3'h1);
      if (wr_phase && wr_idx == SNAPSHOT_LOAD_CTRL_IDX)
        snap_empty <= 1'b0;
      else if (rd_done && rd_idx == EDGE_COUNT_SNAPSHOT_IDX)
        snap_empty <= 1'b1;
    end
  end
  sequence read_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  chk_read_one_wait: assert property (take && !hwrite |=> read_wait)
    else $error("read data phase not one wait state");
  chk_write_no_wait: assert property (take && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  chk_unmapped_zero: assert property (rd_done && !rd_known |-> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_pin_sel_width: assert property (rd_done && rd_mapped && (rd_idx == PHASE_A_PIN_SELECT_IDX ||
    rd_idx == PHASE_B_PIN_SELECT_IDX) |-> hrdata[31:3] == 29'h0)
    else $error("pin selector wider than three bits");
  chk_mode_width: assert property (rd_done && rd_mapped && rd_idx == COUNT_MODE_SELECT_IDX |->
    hrdata[31:1] == 31'h0)
    else $error("mode register wider than one bit");
  chk_load_self_clear: assert property (rd_done && rd_mapped && rd_idx == SNAPSHOT_LOAD_CTRL_IDX &&
    wr_age >= 3'h2 |-> hrdata == 32'h0000_0000)
    else $error("load bit did not clear");
  chk_reset_self_clear: assert property (rd_done && rd_mapped && rd_idx == DECODER_RESET_CTRL_IDX &&
    wr_age >= 3'h2 |-> hrdata == 32'h0000_0000)
    else $error("reset bit did not clear");
  chk_read_clears: assert property (rd_done && rd_mapped && rd_idx == EDGE_COUNT_SNAPSHOT_IDX &&
    snap_empty |-> hrdata == 32'h0000_0000)
    else $error("snapshot not cleared by read");
  chk_hrdata_holds: assert property ($changed(hrdata) |-> $past(rd_stall))
    else $error("read data changed outside a read");
endmodule
bind quadrature_wheel_decoder quadrature_wheel_decoder_props chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .wheel_pin_in(wheel_pin_in));
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import wheel_decoder_pkg::*;
  // Hold covers up to nine filter samples of 1250 cycles at n = 0
  localparam int HOLD = 12000;
  localparam int GLITCH = 2500;
  localparam logic [7:0] IDX_TAB [7] = '{8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd6, 8'hd7, 8'hd8};
  localparam logic [7:0] RST_TAB [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] MSK_TAB [7] = '{8'h00, 8'h37, 8'h07, 8'h07, 8'h00, 8'h01, 8'h00};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic [1:0] hresp;
  logic [7:0] wheel_pin_in;
  int error_cnt = 0;
  int checks = 0;
  assign hready = hreadyout;
  initial
  begin
    forever #12.5 hclk = ~hclk;
  end
  quadrature_wheel_decoder uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .wheel_pin_in(wheel_pin_in));
  wheel_encoder_model #(.PIN_A(3), .PIN_B(5)) enc (.hclk(hclk), .wheel_pin_in(wheel_pin_in));
  task automatic final_report();
    $display("Checks %0d, errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_ready();
    int k;
    k = 0;
    do
    begin
      @(posedge hclk);
      k++;
    end
    while (hreadyout !== 1'b1 && k < 16);
    if (hreadyout !== 1'b1)
    begin
      error_cnt++;
      final_report();
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] rdv);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, wd};
    wait_ready();
    rdv = hrdata;
  endtask
  task automatic write_reg(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] unused;
    bus(1'b1, idx, d, unused);
  endtask
  task automatic read_check(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] v;
    bus(1'b0, idx, 8'h00, v);
    check(v, {24'h00_0000, exp});
  endtask
  task automatic load_read(input logic [7:0] exp);
    write_reg(SNAPSHOT_LOAD_CTRL_IDX, 8'h01);
    read_check(EDGE_COUNT_SNAPSHOT_IDX, exp);
  endtask
  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 7; i++)
      read_check(IDX_TAB[i], RST_TAB[i]);
    read_check(8'hd4, 8'h00);
    for (int i = 0; i < 7; i++)
    begin
      write_reg(IDX_TAB[i], 8'hff);
      read_check(IDX_TAB[i], MSK_TAB[i]);
    end
    write_reg(FILTER_POLARITY_CONFIG_IDX, 8'h00);
    write_reg(PHASE_A_PIN_SELECT_IDX, 8'h03);
    write_reg(PHASE_B_PIN_SELECT_IDX, 8'h05);
    write_reg(COUNT_MODE_SELECT_IDX, 8'h01);
    write_reg(DECODER_RESET_CTRL_IDX, 8'h01);
    enc.move(1'b1, 1'b0, HOLD);
    enc.move(1'b1, 1'b1, HOLD);
    load_read(8'h02);
    read_check(EDGE_COUNT_SNAPSHOT_IDX, 8'h00);
    // Idle high with both pins high; a low pin is an active pulse
    write_reg(FILTER_POLARITY_CONFIG_IDX, 8'h30);
    write_reg(COUNT_MODE_SELECT_IDX, 8'h00);
    write_reg(DECODER_RESET_CTRL_IDX, 8'h01);
    // Shuttle pulse on phase B only counts down, through the wrap
    enc.move(1'b1, 1'b0, HOLD);
    load_read(8'hff);
    enc.move(1'b1, 1'b1, HOLD);
    write_reg(FILTER_POLARITY_CONFIG_IDX, 8'h10);
    // Phase B leads away from the idle-high level
    enc.move(1'b1, 1'b0, HOLD);
    read_check(EDGE_COUNT_SNAPSHOT_IDX, 8'h00);
    enc.move(1'b0, 1'b0, HOLD);
    load_read(8'hfe);
    // Pulse of two samples breaks the hold time; a passed pulse would count down in common mode
    enc.move(1'b1, 1'b0, GLITCH);
    enc.move(1'b0, 1'b0, HOLD);
    load_read(8'hfe);
    write_reg(DECODER_RESET_CTRL_IDX, 8'h01);
    load_read(8'h00);
    final_report();
  end
endmodule
`default_nettype wire
